// file: rtl/cmpd_top.sv
// Digital control around a two-channel analog comparator
// Assumes raw comparator results and timer/pin inputs are asynchronous to ref_clk_i
//
// Contract
// - raw result high when plus exceeds minus
// - invert bits flip each reported result
// - output bits are read only
// - routed pins carry unsynchronised results
// - direction bits still enable routed pins
// - gate source select: pin or comparator 2
// - sync bit latches comparator 2 on fall
// - capture uses prescaled timer clock
// - change flags set on result change
// - flags cleared by zero, set by one
// - request needs three enables, flags still set
// - main register access ends mismatch
// - mismatch keeps setting flags after clear
// - change during main access still sets its flag
// - mode field selects eight routing modes
// - enabled comparators wake device from sleep
// - wake leaves control registers unchanged
// - mode 111 and reference off save power
// - reference gives 16 levels per range
// - analog pins read zero on port read
// - reset forces reset mode, reference off
`timescale 1ns/10ps
`include "cmpd_regs.svh"

module cmpd_top (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  // Register bus
  input  wire cmpd_pkg::cmpd_bus_req_t bus_req_i,
  output logic [7:0]                  bus_rdata_o,
  // Comparator raw results and comparator input pins
  input  wire logic [1:0]             cmp_raw_i,
  input  wire logic [3:0]             port_pin_i,
  output logic [3:0]                  port_rd_o,
  // Comparator output pins
  input  wire logic [1:0]             port_dir_i,
  output logic [1:0]                  cmp_pin_o,
  output logic [1:0]                  cmp_pin_oe_n_o,
  // Timer gate
  input  wire logic                   timer_clk_i,
  input  wire logic                   timer_gate_pin_i,
  output logic                        timer_gate_o,
  // Interrupt and sleep
  input  wire logic                   sleep_i,
  output logic                        irq_req_o,
  output logic                        wake_o,
  output logic                        wake_to_vector_o,
  // Reference and mode status
  output logic                        ref_enable_o,
  output logic [6:0]                  ref_level_o,
  output logic [2:0]                  mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match against a register index
  function automatic logic addr_hit(input logic [9:0] addr, input logic [7:0] idx);
    addr_hit = (addr == {idx, 2'h0});
  endfunction : addr_hit

  // Reference level in 96ths of supply
  function automatic logic [6:0] ref_level(input logic en, input logic rng,
                                           input logic [3:0] code);
    logic [6:0] c;
    c = {3'h0, code};
    if (!en) begin
      ref_level = 7'h00;
    end else if (rng) begin
      ref_level = 7'(c * 7'h04);
    end else begin
      ref_level = 7'(7'h18 + c * 7'h03);
    end
  endfunction : ref_level

  ////////////////////////////////////////////////////////////////////////////
  // State

  cmpd_pkg::cmpd_state_t st_q;
  cmpd_pkg::cmpd_state_t st_d;

  logic       cmp_on;
  logic [1:0] result;
  logic [1:0] mismatch;
  logic       main_access;
  logic       tclk_fall;
  logic       pin_route;
  logic       pending;

  // Reset images of the control registers, sliced field by field at reset
  localparam logic [7:0] main_reset_img = `CMPD_MAIN_RESET;
  localparam logic [1:0] sec_reset_img  = `CMPD_SEC_RESET;
  localparam logic [7:0] ref_reset_img  = `CMPD_REF_RESET;

  // Derived terms of the current state
  always_comb begin
    cmp_on      = (st_q.mode != `CMPD_MODE_RESET) && (st_q.mode != `CMPD_MODE_OFF);
    result      = cmp_on ? (st_q.cmp_res ^ st_q.inv) : 2'h0;
    mismatch    = result ^ st_q.copy;
    main_access = (bus_req_i.we || bus_req_i.re) &&
                  addr_hit(bus_req_i.addr, `CMPD_IDX_MAIN);
    tclk_fall   = (st_q.tclk_s[1] == st_q.tclk_s[2]) && !st_q.tclk_s[2] &&
                  st_q.tclk_lvl;
    pin_route   = (st_q.mode == `CMPD_MODE_PINOUT);
    pending     = |(st_q.flag & st_q.flag_en) && st_q.peripheral_irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0] fl;
    fl   = st_q.flag;
    st_d = st_q;
    // Three-stage synchronisers; a comparator, timer clock or gate change counts once stages two and three agree
    st_d.cmp_s1  = cmp_raw_i;
    st_d.cmp_s2  = st_q.cmp_s1;
    st_d.cmp_s3  = st_q.cmp_s2;
    for (int i = 0; i < 2; i++) begin
      if (st_q.cmp_s2[i] == st_q.cmp_s3[i]) begin
        st_d.cmp_res[i] = st_q.cmp_s3[i];
      end
    end
    st_d.tclk_s  = {st_q.tclk_s[1:0], timer_clk_i};
    if (st_q.tclk_s[1] == st_q.tclk_s[2]) begin
      st_d.tclk_lvl = st_q.tclk_s[2];
    end
    st_d.gate_s  = {st_q.gate_s[1:0], timer_gate_pin_i};
    if (st_q.gate_s[1] == st_q.gate_s[2]) begin
      st_d.gate_lvl = st_q.gate_s[2];
    end
    st_d.port_s1 = port_pin_i;
    st_d.port_s2 = st_q.port_s1;
    st_d.port_s3 = st_q.port_s2;
    // Analog-configured input pins read as zero
    st_d.port_rd = (st_q.mode == `CMPD_MODE_OFF) ? st_q.port_s3 : 4'h0;
    // Comparator 2 capture on the falling prescaled timer clock
    if (tclk_fall) begin
      st_d.c2_latched = result[1];
    end
    // Main register access refreshes the change-detect copy
    if (main_access) begin
      st_d.copy = result;
    end
    // Register writes; output bits are not stored
    if (bus_req_i.we) begin
      if (addr_hit(bus_req_i.addr, `CMPD_IDX_MAIN)) begin
        st_d.inv   = bus_req_i.wdata[`CMPD_MAIN_INV_LSB +: 2];
        st_d.in_sw = bus_req_i.wdata[`CMPD_MAIN_SW_BIT];
        st_d.mode  = bus_req_i.wdata[2:0];
      end
      if (addr_hit(bus_req_i.addr, `CMPD_IDX_SECOND)) begin
        st_d.gss    = bus_req_i.wdata[`CMPD_SEC_GSS_BIT];
        st_d.second_output_sync = bus_req_i.wdata[`CMPD_SEC_SYNC_BIT];
      end
      if (addr_hit(bus_req_i.addr, `CMPD_IDX_REF)) begin
        st_d.ref_en   = bus_req_i.wdata[`CMPD_REF_EN_BIT];
        st_d.ref_rng  = bus_req_i.wdata[`CMPD_REF_RNG_BIT];
        st_d.ref_code = bus_req_i.wdata[3:0];
      end
      if (addr_hit(bus_req_i.addr, `CMPD_IDX_FLAG)) begin
        fl = bus_req_i.wdata[`CMPD_FLAG_LSB +: 2];
      end
      if (addr_hit(bus_req_i.addr, `CMPD_IDX_ENABLE)) begin
        st_d.flag_en = bus_req_i.wdata[`CMPD_FLAG_LSB +: 2];
      end
      if (addr_hit(bus_req_i.addr, `CMPD_IDX_INTCTL)) begin
        st_d.global_irq_enable  = bus_req_i.wdata[`CMPD_INT_GIE_BIT];
        st_d.peripheral_irq_enable = bus_req_i.wdata[`CMPD_INT_PERIPHERAL_IRQ_ENABLE_BIT];
      end
    end
    // Mismatch sets flags every cycle; set wins over a software clear
    // A change during a main read still sets its flag, so no event is lost
    st_d.flag = fl | mismatch;
    // Read data, valid in the cycle after the strobe only
    st_d.rdata = 8'h00;
    if (bus_req_i.re) begin
      if (addr_hit(bus_req_i.addr, `CMPD_IDX_MAIN)) begin
        st_d.rdata = {result, st_q.inv, st_q.in_sw, st_q.mode};
      end else if (addr_hit(bus_req_i.addr, `CMPD_IDX_SECOND)) begin
        st_d.rdata = {6'h00, st_q.gss, st_q.second_output_sync};
      end else if (addr_hit(bus_req_i.addr, `CMPD_IDX_REF)) begin
        st_d.rdata = {st_q.ref_en, 1'h0, st_q.ref_rng, 1'h0, st_q.ref_code};
      end else if (addr_hit(bus_req_i.addr, `CMPD_IDX_FLAG)) begin
        st_d.rdata = {3'h0, st_q.flag, 3'h0};
      end else if (addr_hit(bus_req_i.addr, `CMPD_IDX_ENABLE)) begin
        st_d.rdata = {3'h0, st_q.flag_en, 3'h0};
      end else if (addr_hit(bus_req_i.addr, `CMPD_IDX_INTCTL)) begin
        st_d.rdata = {st_q.global_irq_enable, st_q.peripheral_irq_enable, 6'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; sleep never touches control state

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q          <= '0;
      st_q.mode     <= main_reset_img[2:0];
      st_q.inv      <= main_reset_img[`CMPD_MAIN_INV_LSB +: 2];
      st_q.gss      <= sec_reset_img[`CMPD_SEC_GSS_BIT];
      st_q.second_output_sync   <= sec_reset_img[`CMPD_SEC_SYNC_BIT];
      st_q.ref_en   <= ref_reset_img[`CMPD_REF_EN_BIT];
      st_q.ref_rng  <= ref_reset_img[`CMPD_REF_RNG_BIT];
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Pin multiplexer bypasses all synchronisation
  always_comb begin
    cmp_pin_o      = cmp_on ? (cmp_raw_i ^ st_q.inv) : 2'h0;
    cmp_pin_oe_n_o = pin_route ? port_dir_i : 2'h3;
  end

  // Gate, interrupt, wake and register-backed outputs
  always_comb begin
    timer_gate_o     = st_q.gss ? st_q.gate_lvl
                                : (st_q.second_output_sync ? st_q.c2_latched : result[1]);
    irq_req_o        = pending && st_q.global_irq_enable;
    wake_o           = sleep_i && pending && cmp_on;
    wake_to_vector_o = st_q.global_irq_enable;
    ref_enable_o     = st_q.ref_en;
    ref_level_o      = ref_level(st_q.ref_en, st_q.ref_rng, st_q.ref_code);
    mode_o           = st_q.mode;
    bus_rdata_o      = st_q.rdata;
    port_rd_o        = st_q.port_rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_main_read;
    bus_req_i.re && addr_hit(bus_req_i.addr, `CMPD_IDX_MAIN);
  endsequence

  sequence s_sec_read;
    bus_req_i.re && addr_hit(bus_req_i.addr, `CMPD_IDX_SECOND);
  endsequence

  sequence s_main_write;
    bus_req_i.we && addr_hit(bus_req_i.addr, `CMPD_IDX_MAIN);
  endsequence

  sequence s_flag_write;
    bus_req_i.we && addr_hit(bus_req_i.addr, `CMPD_IDX_FLAG);
  endsequence

  a_flag_sets: assert property (mismatch[0] |=> st_q.flag[0] [*1])
    else $error("change flag 0 not set on mismatch");

  a_mismatch_holds: assert property (mismatch[1] && !main_access |=> st_q.flag[1])
    else $error("flag 1 cleared while mismatch persists");

  a_copy_refresh: assert property (main_access |=> st_q.copy == $past(result))
    else $error("copy not refreshed on main access");

  a_out_readback: assert property (s_main_read |=> bus_rdata_o[7:6] == $past(result))
    else $error("main read does not show live results");

  a_sec_readback: assert property (s_sec_read |=>
                                   bus_rdata_o == {6'h00, $past(st_q.gss), $past(st_q.second_output_sync)})
    else $error("second control readback wrong");

  a_irq_gates: assert property (irq_req_o |-> st_q.global_irq_enable && st_q.peripheral_irq_enable && |st_q.flag_en)
    else $error("interrupt request without all enables");

  a_c2_capture: assert property (st_q.second_output_sync && tclk_fall |=>
                                 st_q.c2_latched == $past(result[1]))
    else $error("comparator 2 not captured on falling timer clock");

  a_gate_pin: assert property (st_q.gss && $stable(st_q.gss) |-> timer_gate_o == st_q.gate_lvl)
    else $error("gate source is not the pin");

  a_pin_oe: assert property (pin_route |-> cmp_pin_oe_n_o == port_dir_i)
    else $error("pin enable ignores direction bits");

  a_mode_off: assert property (st_q.mode == `CMPD_MODE_OFF |-> result == 2'h0 && !wake_o)
    else $error("comparators active in off mode");

  a_ref_off: assert property (!st_q.ref_en |-> ref_level_o == 7'h00)
    else $error("reference level nonzero while off");

  a_port_zero: assert property (st_q.mode != `CMPD_MODE_OFF |=> port_rd_o == 4'h0)
    else $error("analog pin reads nonzero");

  a_reset_vals: assert property ($past(rst_i) |-> st_q.mode == 3'h0 && st_q.gss && !st_q.ref_en)
    else $error("reset values wrong");

  a_flag1_sets: assert property (mismatch[1] |=> st_q.flag[1])
    else $error("change flag 1 not set on mismatch");

  a_flag_write: assert property (s_flag_write |=> st_q.flag == ($past(bus_req_i.wdata[`CMPD_FLAG_LSB +: 2]) | $past(mismatch)))
    else $error("flag write does not land");

  a_irq_level: assert property (st_q.global_irq_enable && st_q.peripheral_irq_enable && |(st_q.flag & st_q.flag_en) |-> irq_req_o)
    else $error("interrupt missing with all enables set");

  a_oe_unrouted: assert property (!pin_route |-> cmp_pin_oe_n_o == 2'h3)
    else $error("pin driven while not routed");

  a_gate_comp: assert property (!st_q.gss && !st_q.second_output_sync |-> timer_gate_o == result[1])
    else $error("unlatched comparator 2 not on gate");

  a_gate_sync: assert property (!st_q.gss && st_q.second_output_sync |-> timer_gate_o == st_q.c2_latched)
    else $error("latched comparator 2 not on gate");

  a_c2_hold: assert property (!tclk_fall |=> $stable(st_q.c2_latched))
    else $error("comparator 2 latch moved without timer fall");

  a_ref_low: assert property (st_q.ref_en && st_q.ref_rng |-> ref_level_o == {1'b0, st_q.ref_code, 2'h0})
    else $error("low range level wrong");

  a_ref_high: assert property (st_q.ref_en && !st_q.ref_rng |-> ref_level_o >= 7'h18 && ref_level_o <= 7'h45)
    else $error("high range level out of span");

  a_rdata_idle: assert property (!bus_req_i.re |=> bus_rdata_o == 8'h00)
    else $error("read data stands without a read");

  a_wake_gate: assert property (wake_o |-> sleep_i && cmp_on && st_q.peripheral_irq_enable)
    else $error("wake without sleep or enabled comparators");

  a_sleep_keeps: assert property (sleep_i && !bus_req_i.we |=> $stable(st_q.mode) && $stable(st_q.ref_en) && $stable(st_q.gss))
    else $error("control state changed during sleep");

  a_copy_hold: assert property (!main_access |=> $stable(st_q.copy))
    else $error("copy changed without main access");

  a_mode_write: assert property (s_main_write |=> st_q.mode == $past(bus_req_i.wdata[2:0]))
    else $error("mode write does not land");

endmodule : cmpd_top

// file: rtl/cmpd_regs.svh
// Register indices, field positions, reset values of the comparator control block
// Assumes inclusion by the top module and the bench; definitions only
`ifndef CMPD_REGS_SVH
`define CMPD_REGS_SVH
// Register indices; byte address is four times the index
`define CMPD_IDX_MAIN      8'h19
`define CMPD_IDX_SECOND    8'h1A
`define CMPD_IDX_REF       8'h99
`define CMPD_IDX_FLAG      8'h0C
`define CMPD_IDX_ENABLE    8'h8C
`define CMPD_IDX_INTCTL    8'h0B
// Main control fields
`define CMPD_MAIN_OUT_LSB  6
`define CMPD_MAIN_INV_LSB  4
`define CMPD_MAIN_SW_BIT   3
`define CMPD_MAIN_RESET    8'h00
// Second control fields
`define CMPD_SEC_GSS_BIT   1
`define CMPD_SEC_SYNC_BIT  0
`define CMPD_SEC_RESET     2'h2
// Reference control fields
`define CMPD_REF_EN_BIT    7
`define CMPD_REF_RNG_BIT   5
`define CMPD_REF_RESET     8'h00
// Flag and enable fields, interrupt control fields
`define CMPD_FLAG_LSB      3
`define CMPD_INT_GIE_BIT   7
`define CMPD_INT_PERIPHERAL_IRQ_ENABLE_BIT  6
// Mode codes
`define CMPD_MODE_RESET    3'h0
`define CMPD_MODE_PINOUT   3'h6
`define CMPD_MODE_OFF      3'h7
`endif

// file: rtl/cmpd_pkg.sv
// Types of the comparator control block
// Assumes cmpd_regs.svh for all numeric constants
package cmpd_pkg;

  // Register bus request, one cycle per strobe
  typedef struct packed {
    logic       we;
    logic       re;
    logic [9:0] addr;
    logic [7:0] wdata;
  } cmpd_bus_req_t;

  // Entire state of the top module
  typedef struct packed {
    logic [2:0] mode;
    logic       in_sw;
    logic [1:0] inv;
    logic       gss;
    logic       second_output_sync;
    logic       ref_en;
    logic       ref_rng;
    logic [3:0] ref_code;
    logic [1:0] flag;
    logic [1:0] flag_en;
    logic       global_irq_enable;
    logic       peripheral_irq_enable;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [1:0] cmp_s3;
    logic [1:0] cmp_res;
    logic [2:0] tclk_s;
    logic       tclk_lvl;
    logic [2:0] gate_s;
    logic       gate_lvl;
    logic       c2_latched;
    logic [1:0] copy;
    logic [3:0] port_s1;
    logic [3:0] port_s2;
    logic [3:0] port_s3;
    logic [3:0] port_rd;
    logic [7:0] rdata;
  } cmpd_state_t;

endpackage : cmpd_pkg

// file: bench/cmpd_partner.sv
// Model of the analog comparators, the prescaled timer clock and the gate pin
// Assumes the bench sets each input level as an 8-bit code per channel
`timescale 1ns/10ps

module cmpd_partner (
  // Analog levels, channel 1 in the low byte
  input  wire logic [15:0] vin_p_i,
  input  wire logic [15:0] vin_n_i,
  // Timer and gate controls
  input  wire logic        tclk_run_i,
  input  wire logic        gate_lvl_i,
  // Towards the block
  output logic [1:0]       raw_o,
  output logic             tclk_o,
  output logic             gate_o
);
  // High when plus exceeds minus; bench never sets equal levels
  assign raw_o[0] = vin_p_i[7:0] > vin_n_i[7:0];
  assign raw_o[1] = vin_p_i[15:8] > vin_n_i[15:8];
  // Gate pin as driven from outside
  assign gate_o = gate_lvl_i;
  // Prescaled timer clock, unrelated in phase, parked low while stopped
  initial begin
    tclk_o = 1'b0;
    forever begin
      #23;
      tclk_o = tclk_run_i ? ~tclk_o : 1'b0;
    end
  end
endmodule : cmpd_partner

// file: bench/test_cmpd_top.sv
// Self-checking bench of the comparator control block
// Assumes cmpd_pkg, cmpd_regs.svh and cmpd_partner compiled before it
`timescale 1ns/10ps
`include "cmpd_regs.svh"

module test_cmpd_top;
  localparam logic [9:0] A_MAIN = {`CMPD_IDX_MAIN, 2'b00};
  localparam logic [9:0] A_SEC  = {`CMPD_IDX_SECOND, 2'b00};
  localparam logic [9:0] A_REF  = {`CMPD_IDX_REF, 2'b00};
  localparam logic [9:0] A_FLAG = {`CMPD_IDX_FLAG, 2'b00};
  localparam logic [9:0] A_EN   = {`CMPD_IDX_ENABLE, 2'b00};
  localparam logic [9:0] A_INT  = {`CMPD_IDX_INTCTL, 2'b00};
  logic                    ref_clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  cmpd_pkg::cmpd_bus_req_t req = '0;
  logic [15:0]             vp = 16'h1010;
  logic [15:0]             vn = 16'h5050;
  logic                    run = 1'b0;
  logic                    glvl = 1'b0;
  logic                    slp = 1'b0;
  logic [3:0]              pins = 4'hF;
  logic [1:0]              dir = 2'b01;
  logic [1:0]              raw, pin, oe_n;
  logic [2:0]              mode;
  logic [3:0]              prd;
  logic [6:0]              lvl;
  logic [7:0]              rdata;
  logic                    tclk, gpin, gate, irq, wake, vec, ren;
  int                      bad_count = 0;
  int                      samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock, far side and the block
  always #5 ref_clk_i = ~ref_clk_i;
  cmpd_partner far (.vin_p_i(vp), .vin_n_i(vn), .tclk_run_i(run), .gate_lvl_i(glvl),
                    .raw_o(raw), .tclk_o(tclk), .gate_o(gpin));
  cmpd_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(req), .bus_rdata_o(rdata),
                .cmp_raw_i(raw), .port_pin_i(pins), .port_rd_o(prd), .port_dir_i(dir),
                .cmp_pin_o(pin), .cmp_pin_oe_n_o(oe_n), .timer_clk_i(tclk),
                .timer_gate_pin_i(gpin), .timer_gate_o(gate), .sleep_i(slp),
                .irq_req_o(irq), .wake_o(wake), .wake_to_vector_o(vec),
                .ref_enable_o(ren), .ref_level_o(lvl), .mode_o(mode));

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles, comparisons and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req <= '0;
    @(negedge ref_clk_i);
  endtask : wr
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    req <= '0;
    @(negedge ref_clk_i);
    chk(rdata, exp);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : idle
  task automatic setraw(input logic [1:0] r);
    @(posedge ref_clk_i);
    vp <= {r[1] ? 8'hA0 : 8'h10, r[0] ? 8'hA0 : 8'h10};
  endtask : setraw
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Watchdog far beyond the expected run length
  initial begin
    #60000;
    bad_count++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk(A_MAIN, `CMPD_MAIN_RESET);
    rchk(A_SEC, {6'h00, `CMPD_SEC_RESET});
    rchk(A_REF, `CMPD_REF_RESET);
    rchk(10'h3FC, 8'h00);
    chk({5'h00, mode}, 8'h00);
    $display("test reset done");
    setraw(2'b01);
    wr(A_INT, 8'h00);
    wr(A_MAIN, 8'hF6);
    idle(8);
    rchk(A_MAIN, 8'hB6);
    chk({6'h00, pin}, 8'h02);
    chk({6'h00, oe_n}, 8'h01);
    wr(A_MAIN, 8'h06);
    setraw(2'b11);
    @(negedge ref_clk_i);
    chk({6'h00, pin}, 8'h03);
    idle(8);
    rchk(A_MAIN, 8'hC6);
    setraw(2'b01);
    for (int m = 0; m < 8; m++) begin
      wr(A_MAIN, 8'(m));
      idle(8);
      chk({5'h00, mode}, 8'(m));
      chk({4'h0, prd}, (m == 7) ? 8'h0F : 8'h00);
      chk({6'h00, pin}, (m == 0 || m == 7) ? 8'h00 : 8'h01);
      chk({6'h00, oe_n}, (m == 6) ? 8'h01 : 8'h03);
    end
    $display("test outputs done");
    wr(A_MAIN, 8'h06);
    idle(8);
    rchk(A_MAIN, 8'h46);
    wr(A_FLAG, 8'h00);
    rchk(A_FLAG, 8'h00);
    setraw(2'b11);
    idle(8);
    rchk(A_FLAG, 8'h10);
    wr(A_FLAG, 8'h00);
    rchk(A_FLAG, 8'h10);
    rchk(A_MAIN, 8'hC6);
    wr(A_FLAG, 8'h00);
    rchk(A_FLAG, 8'h00);
    wr(A_FLAG, 8'h08);
    rchk(A_FLAG, 8'h08);
    chk({7'h00, irq}, 8'h00);
    wr(A_EN, 8'h08);
    chk({7'h00, irq}, 8'h00);
    wr(A_INT, 8'hC0);
    chk({7'h00, irq}, 8'h01);
    wr(A_INT, 8'h40);
    chk({7'h00, irq}, 8'h00);
    $display("test flags done");
    wr(A_REF, 8'hA5);
    chk({1'b0, lvl}, 8'h14);
    chk({7'h00, ren}, 8'h01);
    @(posedge ref_clk_i);
    slp <= 1'b1;
    @(negedge ref_clk_i);
    chk({7'h00, wake}, 8'h01);
    chk({7'h00, vec}, 8'h00);
    wr(A_INT, 8'hC0);
    chk({7'h00, vec}, 8'h01);
    @(posedge ref_clk_i);
    slp <= 1'b0;
    rchk(A_MAIN, 8'hC6);
    rchk(A_REF, 8'hA5);
    rchk(A_SEC, 8'h02);
    wr(A_REF, 8'h8F);
    chk({1'b0, lvl}, 8'h45);
    wr(A_REF, 8'h2F);
    chk({1'b0, lvl}, 8'h00);
    $display("test sleep and reference done");
    wr(A_SEC, 8'h00);
    idle(8);
    chk({7'h00, gate}, 8'h01);
    setraw(2'b01);
    idle(8);
    chk({7'h00, gate}, 8'h00);
    @(posedge ref_clk_i);
    glvl <= 1'b1;
    wr(A_SEC, 8'h02);
    idle(8);
    chk({7'h00, gate}, 8'h01);
    wr(A_SEC, 8'h01);
    setraw(2'b11);
    idle(8);
    chk({7'h00, gate}, 8'h00);
    @(posedge ref_clk_i);
    run <= 1'b1;
    idle(40);
    run <= 1'b0;
    idle(12);
    chk({7'h00, gate}, 8'h01);
    $display("test timer gate done");
    end_of_test();
  end
endmodule : test_cmpd_top
